// ### tac_top.sv
// tac_top: function control of the shared touch/analog converter.
// assumes adc_value_in is quasi-static around each sample and that
// pen_touch_in is an asynchronous level from the touch detector.
`default_nettype none
`timescale 1ns/10ps
module tac_top #(
  parameter int unsigned SETTLE_CYC [8] = '{
    tac_pkg::settle_cyc(0), tac_pkg::settle_cyc(1), tac_pkg::settle_cyc(2),
    tac_pkg::settle_cyc(3), tac_pkg::settle_cyc(4), tac_pkg::settle_cyc(5),
    tac_pkg::settle_cyc(6), tac_pkg::settle_cyc(7)}
) (
  input  wire logic         clk_sys, // 250 MHz clock
  input  wire logic         rst_n, // async reset, low
  input  wire logic [7:0]   s_axi_awaddr, // write address
  input  wire logic [2:0]   s_axi_awprot, // unused
  input  wire logic         s_axi_awvalid, // write address valid
  output logic              s_axi_awready, // write address ready
  input  wire logic [31:0]  s_axi_wdata, // write data
  input  wire logic [3:0]   s_axi_wstrb, // byte strobes
  input  wire logic         s_axi_wvalid, // write data valid
  output logic              s_axi_wready, // write data ready
  output logic [1:0]        s_axi_bresp, // write response
  output logic              s_axi_bvalid, // response valid
  input  wire logic         s_axi_bready, // response ready
  input  wire logic [7:0]   s_axi_araddr, // read address
  input  wire logic [2:0]   s_axi_arprot, // unused
  input  wire logic         s_axi_arvalid, // read address valid
  output logic              s_axi_arready, // read address ready
  output logic [31:0]       s_axi_rdata, // read data
  output logic [1:0]        s_axi_rresp, // read response
  output logic              s_axi_rvalid, // read data valid
  input  wire logic         s_axi_rready, // read data ready
  input  wire logic         pen_touch_in, // touch detected, async
  input  wire logic [11:0]  adc_value_in, // converter result, async
  output tac_pkg::tac_drv_s panel_drv, // panel driver enables
  output tac_pkg::tac_ch_e  adc_channel, // input mux select
  output logic              adc_power_on, // converter powered
  output logic              adc_sample_out, // sample strobe
  output logic              result_available_out, // high when not busy
  output logic              dac_powerdown // current dac off
);
  typedef struct packed {
    tac_pkg::tac_ph_e                  ph;
    logic [15:0]                       cc;
    logic                              dac_pd;
    logic [tac_pkg::NUM_RES-1:0][11:0] res;
    logic [1:0]                        step;
    logic [4:0]                        avg_n;
    logic [4:0]                        tcnt;
    logic [31:0]                       cnt;
    tac_pkg::tac_ch_e                  ch;
    tac_pkg::tac_drv_s                 drv;
    logic                              pwr;
    logic                              smp;
    logic                              idle;
    logic                              aw_ok;
    logic                              w_ok;
    logic [7:0]                        awa;
    logic [15:0]                       wd;
    logic [1:0]                        ws;
    logic                              awrdy;
    logic                              wrdy;
    logic                              bv;
    logic [1:0]                        bresp;
    logic                              arrdy;
    logic                              rv;
    logic [31:0]                       rdata;
    logic [1:0]                        rresp;
    logic                              pen_s1;
    logic                              pen_s2;
    logic [11:0]                       val_s1;
    logic [11:0]                       val_s2;
  } tac_st_s;
  tac_st_s q, n;

  logic [3:0]  func;
  logic [1:0]  rsel;
  logic [1:0]  asel;
  logic [1:0]  csel;
  logic [2:0]  ssel;
  logic        tick;
  logic        avg_clr;
  logic        avg_add;
  logic [11:0] avg_mean;
  logic [11:0] conv_val;
  logic [4:0]  bits;
  logic [4:0]  avg_tot;
  logic        kick;
  logic        halt;
  logic [15:0] nd;
  logic [7:0]  roff;
  logic [1:0]  nsteps;
  logic [3:0]  base;
  logic        panel;
  logic        repeat_scan;
  tac_pkg::tac_drv_s cdrv;

  // stored control fields
  assign func = q.cc[tac_pkg::FUNC_MSB:tac_pkg::FUNC_LSB];
  assign rsel = q.cc[tac_pkg::RES_LSB+1:tac_pkg::RES_LSB];
  assign asel = q.cc[tac_pkg::AVG_LSB+1:tac_pkg::AVG_LSB];
  assign csel = q.cc[tac_pkg::CLK_LSB+1:tac_pkg::CLK_LSB];
  assign ssel = q.cc[tac_pkg::SET_LSB+2:tac_pkg::SET_LSB];

  // divider runs only while converting to keep tick phase fresh
  tac_clk_div u_div (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .run     (q.ph == tac_pkg::PH_CONV),
    .sel     (csel),
    .tick    (tick)
  );

  tac_avg u_avg (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .clr     (avg_clr),
    .add     (avg_add),
    .smp     (conv_val),
    .sel     (asel),
    .mean    (avg_mean)
  );

  // resolution, averaging depth and sequence tables
  always_comb begin
    case (rsel)
      2'h1:    bits = tac_pkg::BITS_8;
      2'h2:    bits = tac_pkg::BITS_10;
      default: bits = tac_pkg::BITS_12;
    endcase
    case (asel)
      2'h1:    avg_tot = 5'h04;
      2'h2:    avg_tot = 5'h08;
      2'h3:    avg_tot = 5'h10;
      default: avg_tot = 5'h01;
    endcase
    // right-justify the converter word at the chosen resolution
    conv_val = q.val_s2 >> (tac_pkg::BITS_12 - bits);
    // multi-step functions walk consecutive result slots
    nsteps = 2'h0;
    base = func - 4'h3;
    case (func)
      tac_pkg::F_XY:    begin base = 4'(tac_pkg::CH_X);    nsteps = 2'h1; end
      tac_pkg::F_XYZ:   begin base = 4'(tac_pkg::CH_X);    nsteps = 2'h3; end
      tac_pkg::F_Z:     begin base = 4'(tac_pkg::CH_Z1);   nsteps = 2'h1; end
      tac_pkg::F_PORT:  begin base = 4'(tac_pkg::CH_VBAT1); nsteps = 2'h3; end
      4'h6, 4'h7:       base = func - 4'h2;
      4'h8, 4'h9:       base = func - 4'h2;
      4'ha:             base = 4'(tac_pkg::CH_TEMP1);
      tac_pkg::F_TEMP2: base = 4'(tac_pkg::CH_TEMP2);
      default:          base = func - 4'h3;
    endcase
    repeat_scan = (func == tac_pkg::F_XY) || (func == tac_pkg::F_XYZ);
    // panel drivers per measured slot
    cdrv = '0;
    panel = 1'b1;
    case (q.ch)
      tac_pkg::CH_X:   begin cdrv.xp = 1'b1; cdrv.xn = 1'b1; end
      tac_pkg::CH_Y:   begin cdrv.yp = 1'b1; cdrv.yn = 1'b1; end
      tac_pkg::CH_Z1,
      tac_pkg::CH_Z2:  begin cdrv.yp = 1'b1; cdrv.xn = 1'b1; end
      default:         panel = 1'b0;
    endcase
  end

  // next state: bus slave, then converter sequencing
  always_comb begin
    n = q;
    n.smp = 1'b0;
    kick = 1'b0;
    halt = 1'b0;
    avg_clr = 1'b0;
    avg_add = 1'b0;
    nd = 16'h0000;
    roff = s_axi_araddr - tac_pkg::ADDR_RES_BASE;
    // two-flop synchronisers
    n.pen_s1 = pen_touch_in;
    n.pen_s2 = q.pen_s1;
    n.val_s1 = adc_value_in;
    n.val_s2 = q.val_s1;
    // write address and data, accepted in either order
    if (q.awrdy && s_axi_awvalid) begin
      n.awa = s_axi_awaddr;
      n.aw_ok = 1'b1;
      n.awrdy = 1'b0;
    end
    if (q.wrdy && s_axi_wvalid) begin
      n.wd = s_axi_wdata[15:0];
      n.ws = s_axi_wstrb[1:0];
      n.w_ok = 1'b1;
      n.wrdy = 1'b0;
    end
    if (q.aw_ok && q.w_ok) begin
      n.aw_ok = 1'b0;
      n.w_ok = 1'b0;
      n.bv = 1'b1;
      n.bresp = tac_pkg::AXI_OKAY;
      if (q.awa == tac_pkg::ADDR_CONV_CTRL) begin
        nd[15:8] = q.ws[1] ? q.wd[15:8] : q.cc[15:8];
        nd[7:0] = q.ws[0] ? q.wd[7:0] : q.cc[7:0];
        n.cc = nd & tac_pkg::CC_WMASK;
        if (q.ws[1] && q.wd[tac_pkg::STOP_BIT]) begin
          halt = 1'b1;
        end else if (q.ws[1] && nd[tac_pkg::FUNC_MSB:tac_pkg::FUNC_LSB] != tac_pkg::F_NONE) begin
          kick = 1'b1;
        end else if (q.ws[1]) begin
          halt = 1'b1;
        end
      end else if (q.awa == tac_pkg::ADDR_DAC_PWR) begin
        if (q.ws[1]) begin
          n.dac_pd = q.wd[tac_pkg::DAC_PD_BIT];
        end
      end else begin
        n.bresp = tac_pkg::AXI_SLVERR;
      end
    end
    if (q.bv && s_axi_bready) begin
      n.bv = 1'b0;
      n.awrdy = 1'b1;
      n.wrdy = 1'b1;
    end
    // reads answer one cycle after the address is taken
    if (q.arrdy && s_axi_arvalid) begin
      n.arrdy = 1'b0;
      n.rv = 1'b1;
      n.rresp = tac_pkg::AXI_OKAY;
      n.rdata = 32'h0000_0000;
      if (s_axi_araddr == tac_pkg::ADDR_CONV_CTRL) begin
        n.rdata[15:0] = q.cc & tac_pkg::CC_WMASK;
        n.rdata[tac_pkg::MODE_BIT] = q.pen_s2;
        n.rdata[tac_pkg::STOP_BIT] = q.idle;
      end else if (s_axi_araddr == tac_pkg::ADDR_DAC_PWR) begin
        n.rdata[tac_pkg::DAC_PD_BIT] = q.dac_pd;
      end else if (roff[1:0] == 2'h0 && roff[7:2] < 6'(tac_pkg::NUM_RES)) begin
        n.rdata[11:0] = q.res[roff[5:2]];
      end else begin
        n.rresp = tac_pkg::AXI_SLVERR;
      end
    end
    if (q.rv && s_axi_rready) begin
      n.rv = 1'b0;
      n.arrdy = 1'b1;
    end
    // converter sequencer
    case (q.ph)
      tac_pkg::PH_NEXT: begin
        n.ch = tac_pkg::tac_ch_e'(base + {2'h0, q.step});
        n.cnt = 32'h0000_0000;
        if (func >= tac_pkg::F_DRVX) begin
          n.ph = tac_pkg::PH_DRIVE;
          n.drv = '0;
          n.drv.xp = (func == tac_pkg::F_DRVX);
          n.drv.xn = (func != tac_pkg::F_DRVY);
          n.drv.yp = (func != tac_pkg::F_DRVX);
          n.drv.yn = (func == tac_pkg::F_DRVY);
        end else if (q.cc[tac_pkg::MODE_BIT] && func <= tac_pkg::F_Z && !q.pen_s2) begin
          n.ph = tac_pkg::PH_WAIT_PEN;
          n.drv = '0;
        end else begin
          n.ph = tac_pkg::PH_SETTLE;
          n.pwr = 1'b1;
        end
      end
      tac_pkg::PH_WAIT_PEN: begin
        if (q.pen_s2) begin
          n.ph = tac_pkg::PH_NEXT;
        end
      end
      tac_pkg::PH_SETTLE: begin
        n.drv = cdrv;
        // settle applies only where a panel driver turns on
        if (!panel || q.cnt >= SETTLE_CYC[ssel]) begin
          n.ph = tac_pkg::PH_CONV;
          n.cnt = 32'h0000_0000;
          n.tcnt = 5'h00;
          n.avg_n = 5'h00;
          avg_clr = 1'b1;
        end else begin
          n.cnt = q.cnt + 32'h0000_0001;
        end
      end
      tac_pkg::PH_CONV: begin
        if (tick) begin
          n.tcnt = q.tcnt + 5'h01;
          if (q.tcnt + 5'h01 == bits + tac_pkg::SAMPLE_TICKS) begin
            n.tcnt = 5'h00;
            n.smp = 1'b1;
            avg_add = 1'b1;
            n.avg_n = q.avg_n + 5'h01;
            if (q.avg_n + 5'h01 == avg_tot) begin
              n.ph = tac_pkg::PH_STORE;
            end
          end
        end
      end
      tac_pkg::PH_STORE: begin
        n.res[q.ch] = avg_mean;
        if (q.step != nsteps) begin
          n.step = q.step + 2'h1;
          n.ph = tac_pkg::PH_NEXT;
        end else if (repeat_scan && q.pen_s2) begin
          n.step = 2'h0;
          n.ph = tac_pkg::PH_NEXT;
        end else begin
          n.ph = tac_pkg::PH_IDLE;
          n.drv = '0;
          n.pwr = 1'b0;
        end
      end
      tac_pkg::PH_DRIVE: begin
        n.pwr = 1'b0;
      end
      default: begin
        n.drv = '0;
        n.pwr = 1'b0;
      end
    endcase
    // a write overrides the sequencer in the cycle it lands
    if (halt) begin
      n.ph = tac_pkg::PH_IDLE;
      n.drv = '0;
      n.pwr = 1'b0;
    end else if (kick) begin
      n.ph = tac_pkg::PH_NEXT;
      n.step = 2'h0;
    end
    // busy covers every conversion of an average and the store
    n.idle = (n.ph == tac_pkg::PH_IDLE) || (n.ph == tac_pkg::PH_DRIVE) ||
            (n.ph == tac_pkg::PH_WAIT_PEN);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.ph <= tac_pkg::PH_IDLE;
      q.cc <= tac_pkg::CC_RST;
      q.dac_pd <= tac_pkg::DAC_PD_RST;
      q.idle <= 1'b1;
      q.awrdy <= 1'b1;
      q.wrdy <= 1'b1;
      q.arrdy <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // outputs straight from the state register
  assign s_axi_awready = q.awrdy;
  assign s_axi_wready = q.wrdy;
  assign s_axi_bvalid = q.bv;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arrdy;
  assign s_axi_rvalid = q.rv;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign panel_drv = q.drv;
  assign adc_channel = q.ch;
  assign adc_power_on = q.pwr;
  assign adc_sample_out = q.smp;
  assign result_available_out = q.idle;
  assign dac_powerdown = q.dac_pd;
endmodule
`default_nettype wire

// ### tac_pkg.sv
// tac_pkg: shared constants and types of the touch converter control block.
// assumes a 250 MHz system clock and a 32-bit axi4-lite register port.
`default_nettype none
package tac_pkg;

  // clock rate and derived divider ratios
  localparam int CLK_KHZ = 250000;
  localparam int CONV_KHZ [4] = '{8000, 4000, 2000, 1000};
  // settle times in microseconds, code 000 through 111
  localparam int SETTLE_US [8] = '{0, 100, 500, 1000, 5000, 10000, 50000, 100000};
  localparam int CYC_PER_US = CLK_KHZ / 1000;

  // rounds up so the conversion clock never runs above its rate
  function automatic int div_ratio(input int i);
    return (CLK_KHZ + CONV_KHZ[i] - 1) / CONV_KHZ[i];
  endfunction

  function automatic int settle_cyc(input int i);
    return SETTLE_US[i] * CYC_PER_US;
  endfunction

  // register indices; byte address is four times the index
  localparam int IDX_CONV_CTRL = 0;
  localparam int IDX_DAC_PWR   = 2;
  localparam logic [7:0] ADDR_CONV_CTRL = 8'(4 * IDX_CONV_CTRL);
  localparam logic [7:0] ADDR_DAC_PWR   = 8'(4 * IDX_DAC_PWR);
  localparam logic [7:0] ADDR_RES_BASE  = 8'h40;
  localparam int NUM_RES = 10;

  // converter control field positions
  localparam int MODE_BIT = 15;
  localparam int STOP_BIT = 14;
  localparam int FUNC_MSB = 13;
  localparam int FUNC_LSB = 10;
  localparam int RES_LSB  = 8;
  localparam int AVG_LSB  = 6;
  localparam int CLK_LSB  = 4;
  localparam int SET_LSB  = 1;
  localparam logic [15:0] CC_WMASK = 16'hbffe;
  localparam logic [15:0] CC_RST   = 16'h0000;
  localparam int DAC_PD_BIT = 15;
  localparam logic DAC_PD_RST = 1'b1;

  // function codes
  localparam logic [3:0] F_NONE  = 4'h0;
  localparam logic [3:0] F_XY    = 4'h1;
  localparam logic [3:0] F_XYZ   = 4'h2;
  localparam logic [3:0] F_Z     = 4'h5;
  localparam logic [3:0] F_PORT  = 4'hb;
  localparam logic [3:0] F_TEMP2 = 4'hc;
  localparam logic [3:0] F_DRVX  = 4'hd;
  localparam logic [3:0] F_DRVY  = 4'he;
  localparam logic [3:0] F_DRVYX = 4'hf;

  // conversion timing, resolution and bus response codes
  localparam logic [4:0] SAMPLE_TICKS = 5'h01;
  localparam logic [4:0] BITS_12 = 5'h0c;
  localparam logic [4:0] BITS_10 = 5'h0a;
  localparam logic [4:0] BITS_8  = 5'h08;
  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  // result slots, in result register order
  typedef enum logic [3:0] {
    CH_X, CH_Y, CH_Z1, CH_Z2, CH_VBAT1, CH_VBAT2, CH_VAUX1, CH_VAUX2, CH_TEMP1, CH_TEMP2
  } tac_ch_e;

  typedef struct packed {
    logic xp;
    logic xn;
    logic yp;
    logic yn;
  } tac_drv_s;

  typedef enum logic [2:0] {
    PH_IDLE, PH_NEXT, PH_WAIT_PEN, PH_SETTLE, PH_CONV, PH_STORE, PH_DRIVE
  } tac_ph_e;

endpackage
`default_nettype wire

// ### tac_clk_div.sv
// tac_clk_div: conversion clock enable from the system clock.
// assumes sel is stable while run is high.
`default_nettype none
`timescale 1ns/10ps
module tac_clk_div (
  input  wire logic       clk_sys, // system clock
  input  wire logic       rst_n,   // async reset, low
  input  wire logic       run,     // counting enabled
  input  wire logic [1:0] sel,     // rate code
  output logic            tick     // one-cycle enable
);
  typedef struct packed {
    logic [7:0] cnt;
    logic       tick;
  } tac_div_s;
  tac_div_s q, n;
  logic [7:0] last;

  // ratio table, rounded up so rate never exceeds target
  always_comb begin
    case (sel)
      2'h0:    last = 8'(tac_pkg::div_ratio(0) - 1);
      2'h1:    last = 8'(tac_pkg::div_ratio(1) - 1);
      2'h2:    last = 8'(tac_pkg::div_ratio(2) - 1);
      default: last = 8'(tac_pkg::div_ratio(3) - 1);
    endcase
    n = q;
    n.tick = 1'b0;
    if (!run) begin
      n.cnt = 8'h00;
    end else if (q.cnt >= last) begin
      n.cnt = 8'h00;
      n.tick = 1'b1;
    end else begin
      n.cnt = q.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
  assign tick = q.tick;
endmodule
`default_nettype wire

// ### tac_avg.sv
// tac_avg: accumulates samples and divides by the averaging depth.
// assumes clr precedes each batch; depths are powers of two.
`default_nettype none
`timescale 1ns/10ps
module tac_avg (
  input  wire logic        clk_sys, // system clock
  input  wire logic        rst_n,   // async reset, low
  input  wire logic        clr,     // start a new batch
  input  wire logic        add,     // take smp
  input  wire logic [11:0] smp,     // one conversion
  input  wire logic [1:0]  sel,     // depth code
  output logic      [11:0] mean     // batch mean
);
  typedef struct packed {
    logic [15:0] acc;
  } tac_acc_s;
  tac_acc_s q, n;

  // 16 samples of 12 bits fit in 16 bits exactly
  always_comb begin
    n = q;
    if (clr) begin
      n.acc = 16'h0000;
    end else if (add) begin
      n.acc = q.acc + {4'h0, smp};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // shift by log2 of depth: 1, 4, 8, 16
  always_comb begin
    case (sel)
      2'h0:    mean = q.acc[11:0];
      2'h1:    mean = q.acc[13:2];
      2'h2:    mean = q.acc[14:3];
      default: mean = q.acc[15:4];
    endcase
  end
endmodule
`default_nettype wire

// ### tac_props.sv
// tac_props: port-level checks of the converter control block.
// assumes it is bound onto tac_top and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module tac_props (
  input wire logic              clk_sys, // clock
  input wire logic              rst_n, // reset, low
  input wire logic [7:0]        s_axi_awaddr, // write address
  input wire logic              s_axi_awvalid, // aw valid
  input wire logic              s_axi_awready, // aw ready
  input wire logic [31:0]       s_axi_wdata, // write data
  input wire logic [3:0]        s_axi_wstrb, // strobes
  input wire logic              s_axi_wvalid, // w valid
  input wire logic              s_axi_wready, // w ready
  input wire logic              s_axi_bvalid, // b valid
  input wire tac_pkg::tac_drv_s panel_drv, // drivers
  input wire tac_pkg::tac_ch_e  adc_channel, // mux slot
  input wire logic              adc_power_on, // powered
  input wire logic              adc_sample_out, // sample strobe
  input wire logic              result_available_out, // not busy
  input wire logic              dac_powerdown // dac off
);
  logic [7:0]  wa_q;
  logic [15:0] wd_q;
  logic        ws_q;
  // last taken write; the channels may be taken at different edges
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wa_q <= 8'h00;
      wd_q <= 16'h0000;
      ws_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) wa_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) begin
        wd_q <= s_axi_wdata[15:0];
        ws_q <= s_axi_wstrb[1];
      end
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // write acts at the edge where the response rises
  property p_halt;
    $rose(s_axi_bvalid) && wa_q == tac_pkg::ADDR_CONV_CTRL && ws_q
      && (wd_q[14] || wd_q[13:10] == 4'h0)
      |=> !adc_power_on && result_available_out && panel_drv == 4'h0;
  endproperty
  a_halt: assert property (p_halt) else $error("halt not honoured");
  property p_dac;
    $rose(s_axi_bvalid) && wa_q == tac_pkg::ADDR_DAC_PWR && ws_q
      |=> dac_powerdown == wd_q[15];
  endproperty
  a_dac: assert property (p_dac) else $error("dac power bit wrong");
  property p_drv_legal;
    panel_drv inside {4'h0, 4'h3, 4'h6, 4'hc};
  endproperty
  a_drv_legal: assert property (p_drv_legal) else $error("illegal driver pair");
  property p_drv_map;
    adc_sample_out && adc_channel <= tac_pkg::CH_Z2 |-> panel_drv ==
      (adc_channel == tac_pkg::CH_X ? 4'hc : adc_channel == tac_pkg::CH_Y ? 4'h3 : 4'h6);
  endproperty
  a_drv_map: assert property (p_drv_map) else $error("wrong driver at sample");
  property p_settled;
    adc_sample_out && adc_channel <= tac_pkg::CH_Z2 |-> $stable(panel_drv);
  endproperty
  a_settled: assert property (p_settled) else $error("driver not on before sample");
  property p_gap;
    adc_sample_out |=> !adc_sample_out [*8];
  endproperty
  a_gap: assert property (p_gap) else $error("samples too close");
  property p_busy;
    adc_sample_out |-> adc_power_on && !result_available_out;
  endproperty
  a_busy: assert property (p_busy) else $error("sample while idle");
  property p_avail;
    $rose(adc_power_on) |-> !result_available_out [*3];
  endproperty
  a_avail: assert property (p_avail) else $error("busy flag glitch");
  c_halt: cover property ($rose(s_axi_bvalid) && wa_q == tac_pkg::ADDR_CONV_CTRL && wd_q[14]);
  c_x: cover property (adc_sample_out && adc_channel == tac_pkg::CH_X);
  c_dac: cover property ($fell(dac_powerdown));
endmodule
bind tac_top tac_props u_props (.clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .panel_drv, .adc_channel, .adc_power_on, .adc_sample_out, .result_available_out,
  .dac_powerdown);
`default_nettype wire

// ### tac_panel_model.sv
// tac_panel_model: behavioural touch panel and converter front end.
// assumes the bench sets the pen level and a code byte per scenario.
`timescale 1ns/10ps
`default_nettype none
module tac_panel_model (
  input  wire logic             pen_req,      // bench pen level
  input  wire logic [7:0]       code,         // low byte of every powered word
  input  wire tac_pkg::tac_ch_e adc_channel,  // slot selected
  input  wire logic             adc_power_on, // converter powered
  output logic                  pen_touch_in, // touch level
  output logic [11:0]           adc_value_in  // converter word
);
  // slot-coded word; unpowered shows the inverse so a stale value never matches
  always_comb begin
    pen_touch_in = pen_req;
    adc_value_in = {adc_channel, code};
    if (!adc_power_on) adc_value_in = ~{adc_channel, code};
  end
endmodule
`default_nettype wire

// ### tb.sv
// tb: self-checking bench for tac_top over axi4-lite.
// assumes tac_props is bound and tac_panel_model drives the analog side.
`timescale 1ns/10ps
`default_nettype none
module tb;
  typedef struct packed {logic [7:0] a; logic [15:0] d; logic [31:0] e; logic [1:0] r;} tac_row_s;
  localparam tac_row_s ROWS [6] = '{'{8'h00, 16'h03ff, 32'h43fe, 2'h0},
    '{8'h00, 16'h01a5, 32'h41a4, 2'h0}, '{8'h00, 16'h0256, 32'h4256, 2'h0},
    '{8'h08, 16'hffff, 32'h8000, 2'h0}, '{8'h08, 16'h0000, 32'h0, 2'h0},
    '{8'h3c, 16'h1234, 32'h0, 2'h2}};
  localparam logic [7:0] ONE [8] = '{8'h30, 8'h41, 8'h64, 8'h75, 8'h86, 8'h97, 8'ha8, 8'hc9};
  localparam logic [3:0] DRV [3] = '{4'hc, 4'h3, 4'h6};
  logic              clk_sys, rst_n, pen_req, pen_touch_in, adc_power_on, adc_sample_out;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic              s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic              result_available_out, dac_powerdown;
  logic [7:0]        s_axi_awaddr, s_axi_araddr, code;
  logic [31:0]       s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp, rr;
  logic [11:0]       adc_value_in;
  tac_pkg::tac_drv_s panel_drv;
  tac_pkg::tac_ch_e  adc_channel;
  int                n_errors, compares, nsmp;
  tac_top #(.SETTLE_CYC('{0, 4, 8, 12, 16, 20, 24, 28})) dut (.clk_sys, .rst_n, .s_axi_awaddr,
    .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .pen_touch_in, .adc_value_in, .panel_drv, .adc_channel,
    .adc_power_on, .adc_sample_out, .result_available_out, .dac_powerdown);
  tac_panel_model u_panel (.pen_req, .code, .adc_channel, .adc_power_on, .pen_touch_in,
    .adc_value_in);
  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // ready and valid are sampled mid-cycle, so the edge that takes them is known
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
    logic ta, tw, hb;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    hb = 1'b0;
    while (!hb) begin
      @(negedge clk_sys);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid;
      rr = s_axi_bresp;
      @(posedge clk_sys);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    chk(rr, er);
  endtask
  task automatic rdr(input logic [7:0] a);
    logic ta, hr;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    hr = 1'b0;
    while (!hr) begin
      @(negedge clk_sys);
      ta = s_axi_arvalid && s_axi_arready;
      hr = s_axi_rvalid;
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge clk_sys);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask
  task automatic wait_idle;
    repeat (3) @(posedge clk_sys);
    while (result_available_out !== 1'b1) @(posedge clk_sys);
  endtask
  task automatic finish_test;
    if (n_errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // clock, sample counter and watchdog
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(negedge clk_sys) if (adc_sample_out === 1'b1) nsmp++;
  initial begin
    #300000;
    n_errors++;
    finish_test;
  end
  // main sequence
  initial begin
    {rst_n, pen_req, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    code = 8'hc3;
    {n_errors, compares, nsmp} = '0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    rdr(tac_pkg::ADDR_CONV_CTRL);
    chk(rd, 32'h4000);
    rdr(tac_pkg::ADDR_DAC_PWR);
    chk({rd, 3'h0, dac_powerdown}, {32'h8000, 4'h1});
    foreach (ROWS[i]) begin
      wr(ROWS[i].a, ROWS[i].d, ROWS[i].r);
      rdr(ROWS[i].a);
      chk({rr, rd}, {ROWS[i].r, ROWS[i].e});
    end
    chk(dac_powerdown, 1'b0);
    // single-slot codes at 8 bits keep the top byte of the word
    foreach (ONE[i]) begin
      wr(8'h00, {2'b00, ONE[i][7:4], 10'h100}, 2'h0);
      wait_idle;
      rdr(8'h40 + {ONE[i][3:0], 2'b00});
      chk(rd, {24'h0, ONE[i][3:0], 4'hc});
    end
    rdr(8'h40);
    chk(rd, 32'h00c);
    @(posedge clk_sys);
    code <= 8'h5a;
    wr(8'h00, 16'h2c20, 2'h0);
    wait_idle;
    for (int k = 4; k < 8; k++) begin
      rdr(8'h40 + 8'(4 * k));
      chk(rd, {20'h0, 4'(k), 8'h5a});
    end
    // sixteen averaged y conversions at 10 bits
    nsmp = 0;
    wr(8'h00, 16'h12e0, 2'h0);
    @(negedge clk_sys);
    chk(result_available_out, 1'b0);
    wait_idle;
    chk(nsmp, 16);
    rdr(8'h44);
    chk(rd, 32'h056);
    for (int i = 0; i < 3; i++) begin
      wr(8'h00, {2'b00, 4'(13 + i), 10'h000}, 2'h0);
      repeat (2) @(negedge clk_sys);
      chk(panel_drv, DRV[i]);
    end
    // device mode xy scan waits for touch, repeats, then is stopped
    @(posedge clk_sys);
    code <= 8'h33;
    nsmp = 0;
    wr(8'h00, 16'h8502, 2'h0);
    repeat (20) @(posedge clk_sys);
    chk({panel_drv, nsmp}, 36'h0);
    pen_req <= 1'b1;
    while (nsmp < 3) @(posedge clk_sys);
    wr(8'h00, 16'h4000, 2'h0);
    repeat (2) @(negedge clk_sys);
    chk({adc_power_on, result_available_out, panel_drv}, 6'h10);
    rdr(8'h00);
    chk(rd, 32'hc000);
    rdr(8'h40);
    chk(rd, 32'h003);
    finish_test;
  end
endmodule
`default_nettype wire
